// ===== remappable_pin_select.sv
// remappable pin router: APB register file, pin synchronisers, registered pin outputs
// assumes APB3/APB4 master on pclk; pins arrive asynchronously; peripherals on pclk
`timescale 1ns/1ps
`include "pin_select_defs.svh"
module remappable_pin_select #(
	parameter pin_select_pkg::variant_t VARIANT = pin_select_pkg::VARIANT_LARGE,
	parameter int NUM_FUNC = 8,
	parameter logic [NUM_FUNC*5-1:0] FUNC_CODES = {5'h08, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01}
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`IN_PINS-1:0] remappable_pin_in,
	input wire logic [NUM_FUNC-1:0] periph_out,
	output logic [`OUT_PINS-1:0] remappable_pin_out,
	output logic [`OUT_PINS-1:0] remappable_pin_oe,
	output logic spi_slave_select_in
);
	import pin_select_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// elaboration checks

	if (NUM_FUNC < 1 || NUM_FUNC > 30) begin : g_bad_func
		$error("NUM_FUNC must lie between 1 and 30");
	end
	for (genvar k = 0; k < NUM_FUNC; k++) begin : g_chk_code
		if (FUNC_CODES[5*k +: 5] == `CODE_NONE) begin : g_bad_code
			$error("function code 0 is kept for an undriven pin");
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// field presence per package variant

	function automatic logic field_present(input int pin);
		logic small_gap;
		small_gap = (pin == 2) || (pin == 3) || (pin == 5) || (pin == 6) || (pin == 10) || (pin == 11);
		if (VARIANT == VARIANT_SMALL && small_gap) begin
			return 1'b0;
		end
		if (pin >= `FIRST_LARGE_PIN && VARIANT != VARIANT_LARGE) begin
			return 1'b0;
		end
		return 1'b1;
	endfunction

	route_cfg_if #(.NUM_OUT(`OUT_PINS), .NUM_IN(`IN_PINS)) cfg ();

	slave_select_mux u_ss_mux (
		.cfg(cfg.in_mux)
	);

	pin_out_mux #(
		.NUM_FUNC(NUM_FUNC),
		.FUNC_CODES(FUNC_CODES)
	) u_out_mux (
		.cfg(cfg.out_mux),
		.periph_out(periph_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	// APB decode

	apb_state_t state_q;
	logic ss_hit;
	logic out_hit;
	logic [3:0] out_idx;
	logic [`ADDR_W-1:0] out_off;
	logic mapped;
	logic access;
	logic done;
	logic wr_done;

	assign out_off = paddr - `ADDR_OUT_BASE;
	assign ss_hit = (paddr == `ADDR_SS_ROUTE);
	assign out_hit = (paddr >= `ADDR_OUT_BASE) && (paddr <= `ADDR_OUT_LAST) && (paddr[1:0] == 2'b00);
	assign out_idx = out_off[5:2];
	assign mapped = ss_hit || out_hit;
	assign access = psel && penable;
	assign done = access && pready;
	assign wr_done = done && pwrite && mapped;

	// one wait state: pready rises in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					if (access) begin
						state_q <= ST_RESP;
					end
				end
				ST_RESP: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
		end else begin
			pready <= (state_q == ST_IDLE) && access;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= (state_q == ST_IDLE) && access && !mapped;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// routing registers

	route_code_t ss_code_q;
	route_code_t out_code_q [`OUT_PINS];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ss_code_q <= `SS_RESET;
		end else if (wr_done && ss_hit && pstrb[0]) begin
			ss_code_q <= pwdata[`EVEN_MSB:`EVEN_LSB];
		end
	end

	for (genvar p = 0; p < `OUT_PINS; p++) begin : g_out_reg
		localparam logic [3:0] REG_IDX = 4'(p / 2);
		localparam bit ODD = (p % 2) == 1;
		localparam int LANE = ODD ? 1 : 0;
		localparam int LSB = ODD ? `ODD_LSB : `EVEN_LSB;
		if (field_present(p)) begin : g_present
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					out_code_q[p] <= `OUT_RESET;
				end else if (wr_done && out_hit && out_idx == REG_IDX && pstrb[LANE]) begin
					out_code_q[p] <= pwdata[LSB +: `CODE_W];
				end
			end
		end else begin : g_absent
			// absent fields hold no storage and read zero
			assign out_code_q[p] = `OUT_RESET;
		end
		assign cfg.out_code[p] = out_code_q[p];
	end

	assign cfg.ss_code = ss_code_q;

	////////////////////////////////////////////////////////////////////////////////
	// read data

	logic [31:0] rd_word;

	always_comb begin
		rd_word = '0;
		if (ss_hit) begin
			rd_word[`EVEN_MSB:`EVEN_LSB] = ss_code_q;
		end else if (out_hit) begin
			for (int r = 0; r < `OUT_REGS; r++) begin
				if (out_idx == 4'(r)) begin
					rd_word[`EVEN_MSB:`EVEN_LSB] = out_code_q[2*r];
					rd_word[`ODD_MSB:`ODD_LSB] = out_code_q[2*r+1];
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (state_q == ST_IDLE && access && !pwrite) begin
			prdata <= rd_word;
		end else if (done) begin
			prdata <= '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and registered routing outputs

	logic [`IN_PINS-1:0] pin_meta_q;
	logic [`IN_PINS-1:0] pin_sync_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
		end else begin
			pin_meta_q <= remappable_pin_in;
			pin_sync_q <= pin_meta_q;
		end
	end

	assign cfg.pin_sync = pin_sync_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spi_slave_select_in <= 1'b0;
		end else begin
			spi_slave_select_in <= cfg.ss_level;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remappable_pin_out <= '0;
			remappable_pin_oe <= '0;
		end else begin
			remappable_pin_out <= cfg.drv;
			remappable_pin_oe <= cfg.oe;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	logic [12:0] wd_h;
	logic [NUM_FUNC-1:0] per_h;
	logic sel_pin_h;

	always_ff @(posedge pclk) begin
		wd_h <= pwdata[12:0];
		per_h <= periph_out;
	end

	assign sel_pin_h = (ss_code_q <= `CODE_LAST_PIN) ? pin_sync_q[ss_code_q] : 1'b0;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ss_tie_low: assert property (ss_code_q == `CODE_TIE_LOW |=> !spi_slave_select_in)
		else $error("tie-low code did not hold slave select low");
	a_ss_pin_route: assert property ((ss_code_q <= `CODE_LAST_PIN) ##1 $stable(ss_code_q)
		|-> spi_slave_select_in == $past(sel_pin_h))
		else $error("slave select does not follow the chosen pin");
	a_unimpl_read_zero: assert property (done && !pwrite |-> prdata[31:13] == '0 && prdata[7:5] == '0)
		else $error("unimplemented bits read nonzero");
	a_field_write_back: assert property (wr_done && paddr == `ADDR_OUT_BASE + 6 * `ADDR_STEP && pstrb == 4'hF
		|=> out_code_q[13] == wd_h[12:8] && out_code_q[12] == wd_h[4:0])
		else $error("output field write not stored in its place");
	a_small_absent: assert property (VARIANT == VARIANT_SMALL |-> out_code_q[2] == '0 && out_code_q[3] == '0
		&& out_code_q[5] == '0 && out_code_q[6] == '0 && out_code_q[10] == '0 && out_code_q[11] == '0)
		else $error("absent small-variant field holds a value");
	a_large_only: assert property (VARIANT != VARIANT_LARGE |-> out_code_q[16] == '0 && out_code_q[17] == '0
		&& out_code_q[18] == '0 && out_code_q[19] == '0)
		else $error("large-only field holds a value");
	a_func_drive: assert property (out_code_q[0] == FUNC_CODES[4:0]
		|=> remappable_pin_oe[0] && remappable_pin_out[0] == per_h[0])
		else $error("pin 0 not driven by its mapped function");
	a_no_func_idle: assert property (out_code_q[1] == `CODE_NONE |=> !remappable_pin_oe[1])
		else $error("unmapped pin is driven");
	a_ready_timing: assert property (psel && !penable ##1 access |-> !pready ##1 pready)
		else $error("access phase not answered in the second cycle");
	a_unmapped_err: assert property (done && !mapped |-> pslverr)
		else $error("unmapped address not flagged");

	c_write: cover property (wr_done && out_hit);
	c_read: cover property (done && !pwrite && ss_hit);
	c_error: cover property (done && pslverr);
endmodule

// ===== pin_select_defs.svh
// constants of the remappable pin router: field layout, reset values, register offsets
// assumes a 32-bit APB bus with byte addressing and a 12-bit address window
// Summary of operation
// - slave-select field bits 4-0; 0..25 picks pin n, 11111 ties low, others reserved
// - unimplemented bits of all routing registers read zero and ignore writes
// - output register: bits 12-8 drive odd pin, bits 4-0 even pin
// - smallest variant lacks output fields of pins 2, 3, 5, 6, 10, 11
// - output fields of pins 16 to 19 exist on largest variant only
`ifndef PIN_SELECT_DEFS_SVH
`define PIN_SELECT_DEFS_SVH

`define CODE_W 5
`define IN_PINS 26
`define OUT_PINS 20
`define OUT_REGS 10
`define EVEN_LSB 0
`define EVEN_MSB 4
`define ODD_LSB 8
`define ODD_MSB 12
`define CODE_TIE_LOW 5'h1F
`define CODE_LAST_PIN 5'h19
`define CODE_NONE 5'h00
`define SS_RESET 5'h1F
`define OUT_RESET 5'h00
`define ADDR_W 12
`define ADDR_SS_ROUTE 12'h000
`define ADDR_OUT_BASE 12'h004
`define ADDR_STEP 12'h004
`define ADDR_OUT_LAST 12'h028
`define FIRST_LARGE_PIN 16

`endif

// ===== pin_select_pkg.sv
// types shared by the remappable pin router modules
// assumes pin_select_defs.svh is on the include path
package pin_select_pkg;
	typedef logic [4:0] route_code_t;
	typedef enum logic [1:0] {VARIANT_SMALL, VARIANT_MID, VARIANT_LARGE} variant_t;
	typedef enum {ST_IDLE, ST_RESP} apb_state_t;
endpackage

// ===== route_cfg_if.sv
// routing configuration and results passed between the router and its muxes
// assumes one clock domain; the interface holds no logic
`timescale 1ns/1ps
interface route_cfg_if #(parameter int NUM_OUT = 20, parameter int NUM_IN = 26);
	pin_select_pkg::route_code_t ss_code;
	pin_select_pkg::route_code_t out_code [NUM_OUT];
	logic [NUM_IN-1:0] pin_sync;
	logic ss_level;
	logic [NUM_OUT-1:0] drv;
	logic [NUM_OUT-1:0] oe;
	modport ctrl (output ss_code, output out_code, output pin_sync, input ss_level, input drv, input oe);
	modport in_mux (input ss_code, input pin_sync, output ss_level);
	modport out_mux (input out_code, output drv, output oe);
endinterface

// ===== slave_select_mux.sv
// picks the synchronised pin, or a constant low, for the slave-select input
// assumes pin levels are already synchronised to pclk
`timescale 1ns/1ps
`include "pin_select_defs.svh"
module slave_select_mux (
	route_cfg_if.in_mux cfg
);
	import pin_select_pkg::*;

	always_comb begin
		if (cfg.ss_code <= `CODE_LAST_PIN) begin
			cfg.ss_level = cfg.pin_sync[cfg.ss_code];
		end else begin
			// tie-low code and reserved codes both give low
			cfg.ss_level = 1'b0;
		end
	end
endmodule

// ===== pin_out_mux.sv
// per pin: finds the peripheral whose function code matches the pin's field
// assumes peripheral outputs are on pclk; code 0 leaves the pin undriven
`timescale 1ns/1ps
`include "pin_select_defs.svh"
module pin_out_mux #(
	parameter int NUM_FUNC = 8,
	parameter logic [NUM_FUNC*5-1:0] FUNC_CODES = {5'h08, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01}
) (
	route_cfg_if.out_mux cfg,
	input wire logic [NUM_FUNC-1:0] periph_out
);
	import pin_select_pkg::*;

	for (genvar p = 0; p < `OUT_PINS; p++) begin : g_pin
		always_comb begin
			cfg.drv[p] = 1'b0;
			cfg.oe[p] = 1'b0;
			for (int k = 0; k < NUM_FUNC; k++) begin
				if (cfg.out_code[p] != `CODE_NONE && cfg.out_code[p] == FUNC_CODES[5*k +: 5]) begin
					cfg.drv[p] = periph_out[k];
					cfg.oe[p] = 1'b1;
				end
			end
		end
	end
endmodule

// ===== pin_world_model.sv
// peripherals and remappable pins around the router
// assumes the bench sets wanted levels; peripheral levels launch on pclk
`timescale 1ns/1ps
`include "pin_select_defs.svh"
module pin_world_model #(
	parameter int NUM_FUNC = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [`IN_PINS-1:0] pin_want,
	input wire logic [NUM_FUNC-1:0] func_want,
	input wire logic [`OUT_PINS-1:0] pin_out,
	input wire logic [`OUT_PINS-1:0] pin_oe,
	output logic [`IN_PINS-1:0] pin_level,
	output logic [NUM_FUNC-1:0] periph_out
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_out <= '0;
		end else begin
			periph_out <= func_want;
		end
	end
	// a driven pin shows the router's level, others the outside level
	always_comb begin
		pin_level = pin_want;
		for (int i = 0; i < `OUT_PINS; i++) begin
			if (pin_oe[i]) begin
				pin_level[i] = pin_out[i];
			end
		end
	end
endmodule

// ===== tb.sv
// testbench of the remappable pin router, large and small variants
// assumes apb answers with one wait state; pins loop back through the model
`timescale 1ns/1ps
`include "pin_select_defs.svh"
module tb;
	import pin_select_pkg::*;
	logic pclk = 0;
	logic presetn = 0;
	logic psel = 0;
	logic penable = 0;
	logic pwrite = 0;
	logic lv = 0;
	logic pready, pslverr, er, ss_in;
	logic [`ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, prdata_s, rl, rs;
	logic [3:0] pstrb = '0;
	logic [`IN_PINS-1:0] pin_want = '0;
	logic [`IN_PINS-1:0] pin_level;
	logic [7:0] func_want = '0;
	logic [7:0] periph_out;
	logic [`OUT_PINS-1:0] pin_out, pin_oe;
	int n_fail = 0;
	int compares = 0;
	int pins [4] = '{0, 13, 20, 25};
	logic [4:0] ties [2] = '{5'h1F, 5'h1A};

	always #5 pclk = ~pclk;

	remappable_pin_select uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .remappable_pin_in(pin_level), .periph_out(periph_out),
		.remappable_pin_out(pin_out), .remappable_pin_oe(pin_oe), .spi_slave_select_in(ss_in));
	remappable_pin_select #(.VARIANT(VARIANT_SMALL)) uut_small (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.prdata(prdata_s), .pready(), .pslverr(), .remappable_pin_in(pin_level), .periph_out(periph_out),
		.remappable_pin_out(), .remappable_pin_oe(), .spi_slave_select_in());
	pin_world_model #(.NUM_FUNC(8)) world (.pclk(pclk), .presetn(presetn), .pin_want(pin_want),
		.func_want(func_want), .pin_out(pin_out), .pin_oe(pin_oe), .pin_level(pin_level),
		.periph_out(periph_out));

	////////////////////////////////////////
	task automatic apb(input logic [`ADDR_W-1:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rl = prdata;
		rs = prdata_s;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic test_done();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// fields present on the small variant after writing all ones
	function automatic logic [31:0] small_mask(int i);
		case (i)
			0, 3: return 32'h0000_001F;
			2, 6, 9, 10: return 32'h0;
			4: return 32'h0000_1F00;
			default: return 32'h0000_1F1F;
		endcase
	endfunction

	initial begin
		#200000;
		n_fail++;
		test_done();
	end

	////////////////////////////////////////
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 11; i++) begin
			apb(12'(4 * i), 1'b0, 32'h0, 4'h0);
			chk("reset value", (i == 0) ? 32'h1F : 32'h0, rl);
			chk("reset value small", (i == 0) ? 32'h1F : 32'h0, rs);
			apb(12'(4 * i), 1'b1, 32'hFFFF_FFFF, 4'hF);
			apb(12'(4 * i), 1'b0, 32'h0, 4'h0);
			chk("ones read back", (i == 0) ? 32'h1F : 32'h1F1F, rl);
			chk("ones read back small", small_mask(i), rs);
			chk("large only fields", small_mask(i) & 32'h1F1F, rs & 32'h1F1F);
		end
		apb(12'h02C, 1'b1, 32'h1F, 4'hF);
		chk("unmapped write error", 32'h1, {31'h0, er});
		apb(12'h02C, 1'b0, 32'h0, 4'h0);
		chk("unmapped read data", 32'h0, rl);
		apb(12'h014, 1'b1, 32'h0305, 4'h1);
		apb(12'h014, 1'b0, 32'h0, 4'h0);
		chk("even lane only", 32'h1F05, rl);
		apb(12'h014, 1'b1, 32'h0305, 4'h2);
		apb(12'h014, 1'b0, 32'h0, 4'h0);
		chk("odd lane only", 32'h0305, rl);
		// pin 0 from function 0, pin 1 from function 1
		apb(12'h004, 1'b1, 32'h0201, 4'hF);
		for (int j = 0; j < 2; j++) begin
			func_want <= 8'(1 << j);
			repeat (4) @(posedge pclk);
			chk("pin levels", 32'(1 << j), {12'h0, pin_out & pin_oe});
			chk("pin enables", 32'h303, {12'h0, pin_oe});
		end
		for (int k = 0; k < 4; k++) begin
			apb(12'h000, 1'b1, 32'(pins[k]), 4'hF);
			for (int j = 0; j < 2; j++) begin
				lv = (j == 0);
				pin_want <= lv ? (26'h1 << pins[k]) : ~(26'h1 << pins[k]);
				func_want <= {8{lv ^ (pins[k] != 0)}};
				repeat (8) @(posedge pclk);
				chk("slave select level", {31'h0, lv}, {31'h0, ss_in});
			end
		end
		for (int k = 0; k < 2; k++) begin
			apb(12'h000, 1'b1, {27'h0, ties[k]}, 4'hF);
			pin_want <= '1;
			func_want <= '1;
			repeat (8) @(posedge pclk);
			chk("slave select tied low", 32'h0, {31'h0, ss_in});
			apb(12'h000, 1'b0, 32'h0, 4'h0);
			chk("slave select code", {27'h0, ties[k]}, rl);
		end
		test_done();
	end
endmodule
